// [clk_sel_pkg.sv]
// Constants and types shared by the clock selection and boot block.
package clk_sel_pkg;

	// Core clock of the register side, in nanoseconds per cycle.
	localparam int PCLK_PERIOD_NS = 40;

	// Boot-up periods after power-on, in nanoseconds.
	localparam int BOOT_FAST_NS = 550000;
	localparam int BOOT_SLOW_NS = 30000000;

	// Least boot delays in pclk cycles, rounded up.
	localparam int BOOT_FAST_CYCLES =
		(BOOT_FAST_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
	localparam int BOOT_SLOW_CYCLES =
		(BOOT_SLOW_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;

	// Width of the boot delay counter.
	localparam int BOOT_CNT_W = 20;

	// Register byte offsets on the bus.
	localparam logic [7:0] ADDR_CLOCK_MODE = 8'h00;
	localparam logic [7:0] ADDR_CRYSTAL_CTRL = 8'h04;
	localparam logic [7:0] ADDR_RC_TRIM = 8'h08;
	localparam logic [7:0] ADDR_BOOT_STATUS = 8'h0C;

	// Clock mode and crystal control register fields.
	localparam int MODE_HSRC_EN_BIT = 4;
	localparam int MODE_LSRC_EN_BIT = 2;
	localparam int CRYSTAL_EN_BIT = 7;

	// Clock mode values loaded by each calibration option other than disable.
	localparam logic [7:0] MODE_HSRC_DIV2 = 8'h34;
	localparam logic [7:0] MODE_HSRC_DIV4 = 8'h14;
	localparam logic [7:0] MODE_HSRC_DIV8 = 8'h3C;
	localparam logic [7:0] MODE_HSRC_DIV16 = 8'h1C;
	localparam logic [7:0] MODE_HSRC_DIV32 = 8'h7C;
	localparam logic [7:0] MODE_LSRC_DIV1 = 8'hE4;

	// Reset values: both RC oscillators on, low-speed RC selected.
	localparam logic [7:0] MODE_RESET = 8'hF4;
	localparam logic [7:0] CRYSTAL_RESET = 8'h00;
	localparam logic [7:0] TRIM_RESET = 8'h80;

	// Selection key built from clock mode bits 7, 6, 5 and 3.
	localparam logic [3:0] KEY_DIV2 = 4'h2;
	localparam logic [3:0] KEY_DIV4 = 4'h0;
	localparam logic [3:0] KEY_DIV8 = 4'h3;
	localparam logic [3:0] KEY_DIV16 = 4'h1;
	localparam logic [3:0] KEY_DIV32 = 4'h7;
	localparam logic [3:0] KEY_DIV64 = 4'h6;
	localparam logic [3:0] KEY_LSRC = 4'hE;
	localparam logic [3:0] KEY_CRYSTAL = 4'hA;

	// Divider exponents (ratio is two to this power).
	localparam logic [2:0] LOG_DIV1 = 3'h0;
	localparam logic [2:0] LOG_DIV2 = 3'h1;
	localparam logic [2:0] LOG_DIV4 = 3'h2;
	localparam logic [2:0] LOG_DIV8 = 3'h3;
	localparam logic [2:0] LOG_DIV16 = 3'h4;
	localparam logic [2:0] LOG_DIV32 = 3'h5;
	localparam logic [2:0] LOG_DIV64 = 3'h6;

	// Source of the core clock.
	typedef enum logic [1:0] {
		SRC_HSRC,
		SRC_LSRC,
		SRC_CRYSTAL
	} clk_src_t;

	// Calibration option fixed at programming time.
	typedef enum logic [2:0] {
		CAL_DISABLE,
		CAL_DIV2,
		CAL_DIV4,
		CAL_DIV8,
		CAL_DIV16,
		CAL_DIV32,
		CAL_LSRC
	} cal_option_t;

endpackage

// [system_clock_select_boot.sv]
// Core clock source selection, oscillator enables and power-on boot.
//
// What this block does
// - Three oscillators, each with own enable bit.
// - Both RC oscillators enabled from reset, and after a divided high RC calibrated boot.
// - Trim register adjusts high-speed RC frequency.
// - Mode 0x34 selects high-speed RC divided by 2.
// - Mode 0x14 selects high-speed RC divided by 4.
// - Mode 0x3C selects high-speed RC divided by 8.
// - Mode 0x1C selects high-speed RC divided by 16.
// - Mode 0x7C selects high-speed RC divided by 32.
// - Mode 0xE4 selects low-speed RC, high-speed off.
// - Calibrated boot: watchdog off, low RC, pin input.
// - Uncalibrated boot: mode kept, high RC off, watchdog.
// - Boot delay after power-on, fast or normal.
// - Fast boot about 550 us, slow 30 ms.
// - Mode write switches core clock at once.
`timescale 1ns/1ps
module system_clock_select_boot #(
	parameter int BOOT_FAST_COUNT = clk_sel_pkg::BOOT_FAST_CYCLES,
	parameter int BOOT_SLOW_COUNT = clk_sel_pkg::BOOT_SLOW_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fast_boot,
	input wire clk_sel_pkg::cal_option_t cal_option,
	input wire logic [7:0] stored_trim,
	input wire logic high_speed_rc_tick,
	input wire logic low_speed_rc_tick,
	input wire logic crystal_osc_tick,
	output logic high_speed_rc_osc_en,
	output logic low_speed_rc_osc_en,
	output logic crystal_osc_en,
	output logic [7:0] high_speed_rc_trim,
	output logic core_clock_en,
	output logic core_run,
	output logic watchdog_en,
	output logic port_a_bit5_input
);
	import clk_sel_pkg::*;

	// Boot sequence states.
	typedef enum logic [1:0] {
		ST_CAPTURE,
		ST_DELAY,
		ST_APPLY,
		ST_RUN
	} boot_state_t;

	// Maps a clock mode value to its selection key.
	function automatic logic [3:0] mode_key(input logic [7:0] mode);
		mode_key = {mode[7], mode[6], mode[5], mode[3]};
	endfunction

	// Maps a calibration option to the clock mode it loads.
	function automatic logic [7:0] cal_mode(input cal_option_t opt);
		case (opt)
			CAL_DIV2: cal_mode = MODE_HSRC_DIV2;
			CAL_DIV4: cal_mode = MODE_HSRC_DIV4;
			CAL_DIV8: cal_mode = MODE_HSRC_DIV8;
			CAL_DIV16: cal_mode = MODE_HSRC_DIV16;
			CAL_DIV32: cal_mode = MODE_HSRC_DIV32;
			CAL_LSRC: cal_mode = MODE_LSRC_DIV1;
			default: cal_mode = MODE_RESET;
		endcase
	endfunction

	// Current boot state.
	boot_state_t state;
	// Counts pclk cycles of the boot delay.
	logic [BOOT_CNT_W-1:0] boot_count;
	// Boot length and calibration option, caught after reset release.
	logic fast_boot_held;
	cal_option_t cal_held;
	// Software visible registers.
	logic [7:0] clock_mode;
	logic [7:0] crystal_ctrl;
	logic [7:0] rc_trim;
	// Watchdog enable decided at boot.
	logic watchdog;
	// Selection applied last cycle, used to spot a switch.
	logic [3:0] prev_key;

	// Bus decode.
	wire setup_phase = psel && !penable;
	wire access_phase = psel && penable;
	wire hit_mode = paddr == ADDR_CLOCK_MODE;
	wire hit_crystal = paddr == ADDR_CRYSTAL_CTRL;
	wire hit_trim = paddr == ADDR_RC_TRIM;
	wire hit_status = paddr == ADDR_BOOT_STATUS;
	wire mapped = hit_mode || hit_crystal || hit_trim || hit_status;
	// Writes are refused while booting or to read-only or unmapped words.
	wire write_bad = pwrite && (!core_run || hit_status || !mapped);
	wire write_ok = access_phase && pwrite && !write_bad;
	wire read_bad = !pwrite && !mapped;

	// Boot delay length for the held option.
	wire [BOOT_CNT_W-1:0] boot_limit = fast_boot_held ?
		BOOT_CNT_W'(BOOT_FAST_COUNT - 1) :
		BOOT_CNT_W'(BOOT_SLOW_COUNT - 1);

	// Selection of the core clock, decoded from the mode key.
	wire [3:0] key = mode_key(clock_mode);
	clk_src_t src;
	logic [2:0] ratio_log2;

	// Decodes source and divider from the mode register.
	always_comb begin
		src = SRC_HSRC;
		ratio_log2 = LOG_DIV64;
		case (key)
			KEY_DIV2: ratio_log2 = LOG_DIV2;
			KEY_DIV4: ratio_log2 = LOG_DIV4;
			KEY_DIV8: ratio_log2 = LOG_DIV8;
			KEY_DIV16: ratio_log2 = LOG_DIV16;
			KEY_DIV32: ratio_log2 = LOG_DIV32;
			KEY_DIV64: ratio_log2 = LOG_DIV64;
			KEY_LSRC: begin
				// Low-speed RC passes undivided.
				src = SRC_LSRC;
				ratio_log2 = LOG_DIV1;
			end
			KEY_CRYSTAL: begin
				// Crystal passes undivided.
				src = SRC_CRYSTAL;
				ratio_log2 = LOG_DIV1;
			end
			default: begin
				// Unlisted codes fall back to the low-speed RC.
				src = SRC_LSRC;
				ratio_log2 = LOG_DIV1;
			end
		endcase
	end

	// Oscillator enables come straight from their register bits.
	assign high_speed_rc_osc_en = clock_mode[MODE_HSRC_EN_BIT];
	assign low_speed_rc_osc_en = clock_mode[MODE_LSRC_EN_BIT];
	assign crystal_osc_en = crystal_ctrl[CRYSTAL_EN_BIT];
	assign high_speed_rc_trim = rc_trim;

	// A disabled oscillator delivers no ticks.
	wire hsrc_tick = high_speed_rc_tick && high_speed_rc_osc_en;
	wire lsrc_tick = low_speed_rc_tick && low_speed_rc_osc_en;
	wire xtal_tick = crystal_osc_tick && crystal_osc_en;

	// The tick of the selected source feeds the divider.
	wire sel_tick = (src == SRC_HSRC) ? hsrc_tick :
		(src == SRC_LSRC) ? lsrc_tick : xtal_tick;

	// A new selection restarts the divider the same cycle.
	wire switching = key != prev_key;

	// Divided core clock enable; held off until the boot is over.
	logic div_tick;
	tick_divider divider (
		.pclk(pclk),
		.presetn(presetn),
		.src_tick(sel_tick),
		.ratio_log2(ratio_log2),
		.restart(switching),
		.div_tick(div_tick)
	);
	assign core_clock_en = div_tick && core_run;

	// Remembers the applied key so a switch is seen once.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_key <= 4'h0;
		end else begin
			prev_key <= key;
		end
	end

	// Boot sequencer: capture straps, wait, then apply calibration.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_CAPTURE;
			boot_count <= '0;
			fast_boot_held <= 1'b0;
			cal_held <= CAL_DISABLE;
		end else begin
			case (state)
				ST_CAPTURE: begin
					// Straps are caught at the first edge after release.
					fast_boot_held <= fast_boot;
					cal_held <= cal_option;
					boot_count <= '0;
					state <= ST_DELAY;
				end
				ST_DELAY: begin
					// Hold the core until the boot period ends.
					if (boot_count == boot_limit) begin
						state <= ST_APPLY;
					end else begin
						boot_count <= boot_count + 1'b1;
					end
				end
				ST_APPLY: begin
					// Calibration values load in this single cycle.
					state <= ST_RUN;
				end
				ST_RUN: begin
					// Running; stays here until the next reset.
					state <= ST_RUN;
				end
				default: begin
					state <= ST_CAPTURE;
				end
			endcase
		end
	end

	assign core_run = state == ST_RUN;
	assign watchdog_en = watchdog;
	// The pin is configured as input from reset onward.
	assign port_a_bit5_input = 1'b1;

	// Watchdog stays off unless calibration was disabled.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			watchdog <= 1'b0;
		end else if (state == ST_APPLY) begin
			watchdog <= cal_held == CAL_DISABLE;
		end
	end

	// Clock mode register: reset, boot load, then software writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_mode <= MODE_RESET;
		end else if (state == ST_APPLY) begin
			if (cal_held == CAL_DISABLE) begin
				// Keep the mode, turn the untrimmed oscillator off.
				clock_mode[MODE_HSRC_EN_BIT] <= 1'b0;
			end else begin
				clock_mode <= cal_mode(cal_held);
			end
		end else if (write_ok && hit_mode) begin
			clock_mode <= pwdata[7:0];
		end
	end

	// Trim register: the stored calibration result loads once per calibrated boot.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_trim <= TRIM_RESET;
		end else if (state == ST_APPLY && cal_held != CAL_DISABLE) begin
			rc_trim <= stored_trim;
		end else if (write_ok && hit_trim) begin
			rc_trim <= pwdata[7:0];
		end
	end

	// Crystal control register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crystal_ctrl <= CRYSTAL_RESET;
		end else if (write_ok && hit_crystal) begin
			crystal_ctrl <= pwdata[7:0];
		end
	end

	// Boot status word: run flag, watchdog, pin mode, fast boot, source, option.
	// Bits 7:6 stay zero so that the option lands in bits 10:8.
	wire [31:0] status_word = {21'h000000, cal_held, 2'h0, src,
		fast_boot_held, port_a_bit5_input, watchdog, core_run};

	// Read data selected by address.
	wire [31:0] read_mux = hit_mode ? {24'h000000, clock_mode} :
		hit_crystal ? {24'h000000, crystal_ctrl} :
		hit_trim ? {24'h000000, rc_trim} :
		hit_status ? status_word : 32'h00000000;

	// Read data is registered in the setup cycle and shown at access.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup_phase && !pwrite) begin
			prdata <= read_mux;
		end
	end

	// Every access completes in its first access cycle.
	assign pready = 1'b1;
	assign pslverr = access_phase && (write_bad || read_bad);

endmodule // system_clock_select_boot

// [system_clock_select_boot_monitor.sv]
// Checker of register writes, enables and boot outcome at the block ports.
`timescale 1ns/1ps
module system_clock_select_boot_monitor #(
	parameter int BOOT_FAST_COUNT = 5,
	parameter int BOOT_SLOW_COUNT = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire clk_sel_pkg::cal_option_t cal_option,
	input wire logic high_speed_rc_osc_en,
	input wire logic low_speed_rc_osc_en,
	input wire logic crystal_osc_en,
	input wire logic [7:0] high_speed_rc_trim,
	input wire logic core_clock_en,
	input wire logic core_run,
	input wire logic watchdog_en,
	input wire logic port_a_bit5_input
);
	import clk_sel_pkg::*;
	// Cycles spent in boot since reset release.
	int boot_cnt;
	// Accepted write to the given offset.
	wire acc_wr = psel && penable && pwrite && core_run;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Counts boot cycles until the core runs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_cnt <= 0;
		end else if (!core_run) begin
			boot_cnt <= boot_cnt + 1;
		end
	end
	property p_mode_en;
		acc_wr && paddr == ADDR_CLOCK_MODE |=>
			high_speed_rc_osc_en == $past(pwdata[4]) &&
			low_speed_rc_osc_en == $past(pwdata[2]);
	endproperty
	a_mode_en: assert property (p_mode_en)
		else $error("clock mode enables wrong");
	property p_xo_en;
		acc_wr && paddr == ADDR_CRYSTAL_CTRL |=>
			crystal_osc_en == $past(pwdata[7]);
	endproperty
	a_xo_en: assert property (p_xo_en)
		else $error("crystal enable wrong");
	property p_trim;
		acc_wr && paddr == ADDR_RC_TRIM |=>
			high_speed_rc_trim == $past(pwdata[7:0]);
	endproperty
	a_trim: assert property (p_trim)
		else $error("trim wrong");
	property p_wdt;
		$rose(core_run) |-> watchdog_en == (cal_option == CAL_DISABLE);
	endproperty
	a_wdt: assert property (p_wdt)
		else $error("watchdog at boot wrong");
	property p_boot_en;
		$rose(core_run) && cal_option != CAL_DISABLE &&
			cal_option != CAL_LSRC |-> high_speed_rc_osc_en &&
			low_speed_rc_osc_en;
	endproperty
	a_boot_en: assert property (p_boot_en)
		else $error("oscillators off at boot");
	property p_cal_off;
		$rose(core_run) && cal_option == CAL_DISABLE |->
			!high_speed_rc_osc_en;
	endproperty
	a_cal_off: assert property (p_cal_off)
		else $error("high RC on without calibration");
	property p_pin;
		core_run |-> port_a_bit5_input;
	endproperty
	a_pin: assert property (p_pin)
		else $error("pin not input");
	property p_gate;
		core_clock_en |-> core_run;
	endproperty
	a_gate: assert property (p_gate)
		else $error("core clock before boot end");
	property p_boot_len;
		$rose(core_run) |-> boot_cnt >= BOOT_FAST_COUNT &&
			boot_cnt <= BOOT_SLOW_COUNT + 3;
	endproperty
	a_boot_len: assert property (p_boot_len)
		else $error("boot length wrong");
endmodule // system_clock_select_boot_monitor

bind system_clock_select_boot system_clock_select_boot_monitor #(
	.BOOT_FAST_COUNT(BOOT_FAST_COUNT), .BOOT_SLOW_COUNT(BOOT_SLOW_COUNT)
) u_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pslverr(pslverr), .cal_option(cal_option),
	.high_speed_rc_osc_en(high_speed_rc_osc_en),
	.low_speed_rc_osc_en(low_speed_rc_osc_en),
	.crystal_osc_en(crystal_osc_en),
	.high_speed_rc_trim(high_speed_rc_trim),
	.core_clock_en(core_clock_en), .core_run(core_run),
	.watchdog_en(watchdog_en), .port_a_bit5_input(port_a_bit5_input));

// [test_system_clock_select_boot.sv]
// Self-checking bench for the clock selection and boot block.
`timescale 1ns/1ps
module test_system_clock_select_boot;
	import clk_sel_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00, stored_trim = 8'h5A, trim;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, e, fast_boot = 0, ls_tick = 0, xo_tick = 0;
	logic hs_en, ls_en, xo_en, core_clock_en, core_run, wdt, pin_in;
	cal_option_t cal_option = CAL_DISABLE;
	int failures = 0, n_checks = 0, tick_cnt = 0, n;
	// Boot mode per option; switch list keeps the old source on.
	logic [7:0] boot_mode [7] = '{8'hE4, 8'h34, 8'h14, 8'h3C, 8'h1C,
		8'h7C, 8'hE4};
	logic [7:0] modes [8] = '{8'h34, 8'h14, 8'h3C, 8'h1C, 8'h7C, 8'h74,
		8'hF4, 8'hB4};
	int periods [8] = '{2, 4, 8, 16, 32, 64, 3, 5};
	system_clock_select_boot #(.BOOT_FAST_COUNT(5), .BOOT_SLOW_COUNT(20))
	u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .fast_boot(fast_boot),
		.cal_option(cal_option), .stored_trim(stored_trim),
		.high_speed_rc_tick(1'b1), .low_speed_rc_tick(ls_tick),
		.crystal_osc_tick(xo_tick), .high_speed_rc_osc_en(hs_en),
		.low_speed_rc_osc_en(ls_en), .crystal_osc_en(xo_en),
		.high_speed_rc_trim(trim), .core_clock_en(core_clock_en),
		.core_run(core_run), .watchdog_en(wdt), .port_a_bit5_input(pin_in));
	// Clock of 40 ns.
	always #20 pclk = ~pclk;
	// Low RC ticks every third cycle, crystal every fifth.
	always_ff @(posedge pclk) begin
		tick_cnt <= tick_cnt + 1;
		ls_tick <= (tick_cnt % 3) == 0;
		xo_tick <= (tick_cnt % 5) == 0;
	end
	// Prints the counts and the verdict, then stops.
	task summarize();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Compares a seen value with the expected one.
	task check(input string what, input logic [31:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One bus transfer; read data in rd, error in e.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			failures++;
			summarize();
		end
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Holds reset for 10 cycles and releases it.
	task do_reset();
		presetn <= 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
	endtask
	// Waits for boot end; cycle count left in n.
	task wait_run();
		n = 0;
		while (core_run !== 1'b1 && n < 100) begin
			@(negedge pclk);
			n++;
		end
		if (n >= 100) begin
			failures++;
			summarize();
		end
	endtask
	// Checks first pulse latency and the steady core clock period.
	task period(input int exp);
		int k;
		int m;
		k = 0;
		m = 0;
		// The write edge may still show the old selection's last pulse.
		@(negedge pclk);
		do begin
			@(negedge pclk);
			k++;
		end while (core_clock_en !== 1'b1 && k < 100);
		do begin
			@(negedge pclk);
			m++;
		end while (core_clock_en !== 1'b1 && m < 100);
		if (k >= 100 || m >= 100) begin
			failures++;
			summarize();
		end
		check("first", k <= exp + 2, 1);
		check("period", m, exp);
	endtask
	// Boots each option, then registers, refusals and switching.
	initial begin
		for (int i = 0; i < 7; i++) begin
			cal_option <= cal_option_t'(i);
			fast_boot <= i[0];
			do_reset();
			wait_run();
			check("boot", n >= (i[0] ? 5 : 20) &&
				n <= (i[0] ? 8 : 23), 1);
			check("wdt", wdt, i == 0);
			check("hs_en", hs_en, i > 0 && i < 6);
			check("ls_en", ls_en, 1);
			check("pin", pin_in, 1);
			apb(0, ADDR_CLOCK_MODE, 0);
			check("mode", rd, boot_mode[i]);
			apb(0, ADDR_RC_TRIM, 0);
			check("trim", rd, i == 0 ? 32'h80 : 32'h5A);
			$display("boot option %0d done", i);
		end
		do_reset();
		apb(1, ADDR_RC_TRIM, 32'h11);
		check("early_err", e, 1);
		wait_run();
		apb(1, ADDR_CRYSTAL_CTRL, 32'h80);
		check("wr_err", e, 0);
		@(negedge pclk);
		check("xo_en", xo_en, 1);
		apb(1, ADDR_RC_TRIM, 32'hC3);
		@(negedge pclk);
		check("trim_out", trim, 8'hC3);
		apb(0, ADDR_BOOT_STATUS, 0);
		check("status", rd, 32'h00000615);
		apb(1, ADDR_BOOT_STATUS, 32'hFF);
		check("ro_err", e, 1);
		apb(0, 8'h10, 0);
		check("unm_err", e, 1);
		check("unm_data", rd, 0);
		$display("register test done");
		for (int j = 0; j < 8; j++) begin
			apb(1, ADDR_CLOCK_MODE, {24'h0, modes[j]});
			period(periods[j]);
			check("hs_en", hs_en, modes[j][4]);
			check("ls_en", ls_en, modes[j][2]);
		end
		$display("clock switching done");
		summarize();
	end
endmodule // test_system_clock_select_boot

// [tick_divider.sv]
// Divides a one-cycle source tick by a power of two into whole pulses.
`timescale 1ns/1ps
module tick_divider (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic src_tick,
	input wire logic [2:0] ratio_log2,
	input wire logic restart,
	output logic div_tick
);
	import clk_sel_pkg::*;

	// Counts source ticks inside one output period.
	logic [5:0] count;
	// Mask of counter bits that must be all ones for a pulse.
	logic [5:0] mask;
	// High when the current tick closes an output period.
	wire period_end;

	assign mask = 6'(7'h7F >> (3'd7 - ratio_log2));
	assign period_end = src_tick && ((count & mask) == mask);

	// A restart opens a fresh whole period, so no short pulse follows.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= 6'h00;
		end else if (restart) begin
			count <= 6'h00;
		end else if (src_tick) begin
			count <= period_end ? 6'h00 : count + 6'h01;
		end
	end

	// The output pulse comes from a flip-flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_tick <= 1'b0;
		end else begin
			div_tick <= period_end && !restart;
		end
	end

endmodule // tick_divider
